// [rtl/term_cond_pkg.sv]
package term_cond_pkg;

   // ==========================================================
   // Terminal geometry
   localparam int NUM_TERM  = 9;
   localparam int LOW_GROUP = 5;
   localparam int POL_W     = 12;
   localparam int FUNC_W    = 7;
   localparam int TIME_W    = 6;
   localparam int CNT_W     = 16;
   localparam int MS_W      = 17;
   localparam int PERIOD_W  = 21;

   // ==========================================================
   // Register map (word index on the ADDR port)
   localparam logic [3:0] ADDR_LO_TIME   = 4'h0;
   localparam logic [3:0] ADDR_HI_TIME   = 4'h1;
   localparam logic [3:0] ADDR_POLARITY  = 4'h2;
   localparam logic [3:0] ADDR_CONFIG    = 4'h3;
   localparam logic [3:0] ADDR_FUNC_BASE = 4'h4;
   localparam logic [3:0] ADDR_STATUS    = 4'hd;
   localparam logic [3:0] ADDR_COUNT     = 4'he;

   localparam logic [15:0] DEB_TIME_RST = 16'h0005;
   localparam logic [15:0] DEB_TIME_MIN = 16'h0001;
   localparam logic [15:0] DEB_TIME_MAX = 16'h0032;
   localparam logic [11:0] POLARITY_RST = 12'h000;
   localparam logic [3:0]  CONFIG_RST   = 4'h0;
   localparam logic [6:0]  FUNC_RST     = 7'h00;

   // Config register bits
   localparam int CFG_THERMAL = 0;
   localparam int CFG_COMP    = 1;
   localparam int CFG_PHOTO   = 2;
   localparam int CFG_SPINDLE = 3;

   // ==========================================================
   // Terminal function codes
   localparam logic [6:0] FN_LEN_CLR  = 7'h3d;
   localparam logic [6:0] FN_THERMAL  = 7'h3e;
   localparam logic [6:0] FN_COMP1    = 7'h3f;
   localparam logic [6:0] FN_COMP2    = 7'h40;
   localparam logic [6:0] FN_FLUX     = 7'h41;
   localparam logic [6:0] FN_POS_CLR  = 7'h42;
   localparam logic [6:0] FN_DIR      = 7'h44;
   localparam logic [6:0] FN_SERVO    = 7'h45;
   localparam logic [6:0] FN_ORIGIN   = 7'h46;
   localparam logic [6:0] FN_HOME     = 7'h47;
   localparam logic [6:0] FN_ANGLE1   = 7'h48;
   localparam logic [6:0] FN_ANGLE2   = 7'h49;
   localparam logic [6:0] FN_ANGLE3   = 7'h4a;
   localparam logic [6:0] FN_POS_GAIN = 7'h4b;
   localparam logic [6:0] FN_SRV_CLR  = 7'h4d;
   localparam logic [6:0] FN_PULSE_LO = 7'h61;
   localparam logic [6:0] FN_PULSE_HI = 7'h62;

   // ==========================================================
   // Timing
   localparam int CLK_HZ        = 125_000_000;
   localparam int CLK_PERIOD_NS = 8;
   localparam int ONE_MS_NS     = 1_000_000;
   localparam int CYCLES_PER_MS = ONE_MS_NS / CLK_PERIOD_NS;
   localparam int P_LO_MIN_HZ   = 100;
   localparam int P_LO_MAX_HZ   = 100_000;
   localparam int P_HI_MIN_HZ   = 1_000;
   localparam int P_HI_MAX_HZ   = 1_000_000;
   // Shortest legal period rounds up, longest rounds down
   localparam int P_LO_MIN_PER  = (CLK_HZ + P_LO_MAX_HZ - 1) / P_LO_MAX_HZ;
   localparam int P_HI_MIN_PER  = (CLK_HZ + P_HI_MAX_HZ - 1) / P_HI_MAX_HZ;
   localparam int P_LO_MAX_PER  = CLK_HZ / P_LO_MIN_HZ;
   localparam int P_HI_MAX_PER  = CLK_HZ / P_HI_MIN_HZ;

endpackage : term_cond_pkg

// [rtl/input_debounce.sv]
`timescale 1ns/100ps
`default_nettype none
module input_debounce
   import term_cond_pkg::*;
#(
   parameter int N     = NUM_TERM,
   parameter int LOW_N = LOW_GROUP
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              ms_tick,
   input  wire logic [N-1:0]      raw,
   input  wire logic [TIME_W-1:0] lo_time,
   input  wire logic [TIME_W-1:0] hi_time,
   output logic      [N-1:0]      filt
);

   if (LOW_N < 0 || LOW_N > N) begin : g_bad
      $error("input_debounce: LOW_N out of range");
   end

   typedef struct packed {
      logic [N-1:0]             filt;
      logic [N-1:0][TIME_W-1:0] cnt;
   } deb_t;

   deb_t st;
   deb_t nx;

   // ==========================================================
   // Filter
   // One extra tick so a change is held at least the full time
   always_comb begin
      logic [TIME_W-1:0] lim;
      nx  = st;
      lim = '0;
      for (int i = 0; i < N; i++) begin
         lim = (i < LOW_N) ? lo_time : hi_time;
         if (raw[i] == st.filt[i]) begin
            nx.cnt[i] = '0;
         end else if (ms_tick) begin
            if (st.cnt[i] >= lim) begin
               nx.filt[i] = raw[i];
               nx.cnt[i]  = '0;
            end else begin
               nx.cnt[i] = st.cnt[i] + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= nx;
      end
   end

   assign filt = st.filt;

   AST_DEB_TICK: assert property (@(posedge clk) disable iff (rst)
      $changed(filt) |-> $past(ms_tick)
         && ((filt ^ $past(filt)) & (filt ^ $past(raw))) == '0)
      else $error("Filtered level changed without a stable tick");

endmodule : input_debounce
`default_nettype wire

// [rtl/pulse_train_counter.sv]
`timescale 1ns/100ps
`default_nettype none
module pulse_train_counter
   import term_cond_pkg::*;
#(
   parameter int LO_MAX = P_LO_MAX_PER,
   parameter int HI_MAX = P_HI_MAX_PER
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             level,
   input  wire logic             enable,
   input  wire logic             fast,
   input  wire logic             dir_sub,
   input  wire logic             clear,
   output logic      [CNT_W-1:0] count,
   output logic                  rate_ok
);

   if (LO_MAX < 2 || HI_MAX < 2 || LO_MAX >= 2**PERIOD_W
       || HI_MAX >= 2**PERIOD_W) begin : g_bad
      $error("pulse_train_counter: period bound out of range");
   end

   typedef struct packed {
      logic                prev;
      logic [PERIOD_W-1:0] per;
      logic [CNT_W-1:0]    count;
      logic                rate_ok;
   } pls_t;

   pls_t st;
   pls_t nx;
   logic [PERIOD_W-1:0] per_min;
   logic [PERIOD_W-1:0] per_max;

   assign per_min = fast ? PERIOD_W'(P_HI_MIN_PER) : PERIOD_W'(P_LO_MIN_PER);
   assign per_max = fast ? PERIOD_W'(HI_MAX) : PERIOD_W'(LO_MAX);

   // ==========================================================
   // Edge count and rate check
   always_comb begin
      nx      = st;
      nx.prev = level;
      if (st.per <= per_max) begin
         nx.per = st.per + 1'b1;
      end else begin
         nx.rate_ok = 1'b0;
      end
      if (enable && level && !st.prev) begin
         nx.count = dir_sub ? st.count - 1'b1
                            : st.count + 1'b1;
         nx.rate_ok = (st.per + 1'b1 >= per_min)
                   && (st.per + 1'b1 <= per_max);
         nx.per = '0;
      end
      if (!enable) begin
         nx.rate_ok = 1'b0;
      end
      if (clear) begin
         nx.count = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= nx;
      end
   end

   assign count   = st.count;
   assign rate_ok = st.rate_ok;

   AST_CNT_CLR: assert property (@(posedge clk) disable iff (rst)
      clear |=> count == '0)
      else $error("Pulse count not cleared");

   AST_RATE_LOST: assert property (@(posedge clk) disable iff (rst)
      st.per > per_max && !(enable && level && !st.prev) |=> !rate_ok)
      else $error("Rate flag kept after period overrun");

endmodule : pulse_train_counter
`default_nettype wire

// [rtl/input_terminal_conditioning.sv]
// Overview of operation
// - Code 61 rising clears single-pulse length
// - Code 62 is thermal switch when configured
// - Codes 63,64 select comp gain when configured
// - Gain selector 00..11 picks sets 1..4
// - Code 65 flux brake only while decelerating
// - Code 66 assertion clears position pulse counter
// - Code 68 selects servo pulse add/subtract
// - Code 69 switches servo position/torque control
// - Code 70 is origin when photoelectric configured
// - Code 71 homes spindle, release drops torque
// - Codes 72-74 form angle selector, 74 MSB
// - Selector 0 normal, 1-7 hold angle
// - Code 75 picks position loop gain set
// - Code 77 clears servo pulse count
// - Code 97 pulse range 0.10-100 kHz
// - Code 98 pulse range 1.0-1000 kHz
// - Terminals 1-5 share 1-50 ms filter
// - Terminals 6-9 use second 1-50 ms filter
// - Accept change only after stable filter time
// - Twelve-bit polarity, default zero, 1 negative
// - Positive logic: closed contact means active
// - Negative logic: open contact means active
`timescale 1ns/100ps
`default_nettype none
module input_terminal_conditioning
   import term_cond_pkg::*;
#(
   parameter int MS_CYCLES = CYCLES_PER_MS,
   parameter int LO_MAX    = P_LO_MAX_PER,
   parameter int HI_MAX    = P_HI_MAX_PER
) (
   input  wire logic                CLK,
   input  wire logic                RST,
   input  wire logic [NUM_TERM-1:0] TERM_CLOSED,
   input  wire logic                DECEL_STOP,
   input  wire logic [3:0]          ADDR,
   input  wire logic [15:0]         WDATA,
   input  wire logic                WR,
   input  wire logic                RD,
   output logic      [15:0]         RDATA,
   output logic      [NUM_TERM-1:0] TERM_STATE,
   output logic                     LENGTH_CLEAR,
   output logic                     THERMAL_SWITCH,
   output logic      [1:0]          COMP_GAIN_SET,
   output logic                     FLUX_BRAKE,
   output logic                     POS_COUNT_CLEAR,
   output logic                     SERVO_DIR_SUB,
   output logic                     SERVO_MODE,
   output logic                     SPINDLE_ORIGIN,
   output logic                     SPINDLE_HOME,
   output logic      [2:0]          SPINDLE_ANGLE,
   output logic                     SPINDLE_HOLD,
   output logic                     POS_GAIN_SEL,
   output logic                     SERVO_COUNT_CLEAR,
   output logic      [CNT_W-1:0]    PULSE_COUNT,
   output logic                     PULSE_RATE_OK
);

   if (MS_CYCLES < 2 || MS_CYCLES >= 2**MS_W) begin : g_bad
      $error("input_terminal_conditioning: MS_CYCLES out of range");
   end

   typedef logic [NUM_TERM-1:0][FUNC_W-1:0] func_arr_t;

   typedef struct packed {
      logic [TIME_W-1:0] lo_time;
      logic [TIME_W-1:0] hi_time;
      logic [POL_W-1:0]  polarity;
      logic [3:0]        cfg;
      func_arr_t         func;
      logic [MS_W-1:0]   ms_cnt;
      logic              ms_tick;
      logic [NUM_TERM-1:0] raw;
      logic [2:0]        prev;
      logic [15:0]       rdata;
      logic              len_clr;
      logic              thermal;
      logic [1:0]        comp_gain;
      logic              flux;
      logic              pos_clr;
      logic              dir_sub;
      logic              servo;
      logic              origin;
      logic              home;
      logic [2:0]        angle;
      logic              hold;
      logic              pos_gain;
      logic              srv_clr;
   } top_t;

   top_t st;
   top_t nx;

   logic [NUM_TERM-1:0] filt;
   logic [CNT_W-1:0]    count;
   logic                rate_ok;
   logic                pulse_en;
   logic                pulse_fast;

   // ==========================================================
   // Decoding helpers
   function automatic logic fn_level(input func_arr_t fsel,
                                     input logic [NUM_TERM-1:0] lvl,
                                     input logic [FUNC_W-1:0] code);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < NUM_TERM; i++) begin
         if (fsel[i] == code && lvl[i]) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction : fn_level

   // Out-of-range settings are pulled into 1..50 on write
   function automatic logic [TIME_W-1:0] fn_clamp(input logic [15:0] v);
      if (v < DEB_TIME_MIN) begin
         return TIME_W'(DEB_TIME_MIN);
      end else if (v > DEB_TIME_MAX) begin
         return TIME_W'(DEB_TIME_MAX);
      end
      return v[TIME_W-1:0];
   endfunction : fn_clamp

   // ==========================================================
   // Function routing of the filtered levels
   logic lv_len, lv_therm, lv_c1, lv_c2, lv_flux, lv_pclr, lv_dir;
   logic lv_servo, lv_org, lv_home, lv_a1, lv_a2, lv_a3, lv_pg, lv_sclr;

   assign lv_len   = fn_level(st.func, filt, FN_LEN_CLR);
   assign lv_therm = fn_level(st.func, filt, FN_THERMAL);
   assign lv_c1    = fn_level(st.func, filt, FN_COMP1);
   assign lv_c2    = fn_level(st.func, filt, FN_COMP2);
   assign lv_flux  = fn_level(st.func, filt, FN_FLUX);
   assign lv_pclr  = fn_level(st.func, filt, FN_POS_CLR);
   assign lv_dir   = fn_level(st.func, filt, FN_DIR);
   assign lv_servo = fn_level(st.func, filt, FN_SERVO);
   assign lv_org   = fn_level(st.func, filt, FN_ORIGIN);
   assign lv_home  = fn_level(st.func, filt, FN_HOME);
   assign lv_a1    = fn_level(st.func, filt, FN_ANGLE1);
   assign lv_a2    = fn_level(st.func, filt, FN_ANGLE2);
   assign lv_a3    = fn_level(st.func, filt, FN_ANGLE3);
   assign lv_pg    = fn_level(st.func, filt, FN_POS_GAIN);
   assign lv_sclr  = fn_level(st.func, filt, FN_SRV_CLR);

   // Only the last terminal can take a pulse train
   assign pulse_fast = st.func[NUM_TERM-1] == FN_PULSE_HI;
   assign pulse_en   = pulse_fast
                    || st.func[NUM_TERM-1] == FN_PULSE_LO;

   // ==========================================================
   // Next state
   always_comb begin
      logic [3:0] fidx;
      nx   = st;
      fidx = ADDR - ADDR_FUNC_BASE;

      // Polarity applied to raw contacts before filtering
      nx.raw = TERM_CLOSED ^ st.polarity[NUM_TERM-1:0];

      nx.ms_tick = 1'b0;
      if (st.ms_cnt == MS_W'(MS_CYCLES - 1)) begin
         nx.ms_cnt  = '0;
         nx.ms_tick = 1'b1;
      end else begin
         nx.ms_cnt = st.ms_cnt + 1'b1;
      end

      // Clears act once per assertion, not while held
      nx.prev    = {lv_sclr, lv_pclr, lv_len};
      nx.len_clr = lv_len & ~st.prev[0];
      nx.pos_clr = lv_pclr & ~st.prev[1];
      nx.srv_clr = lv_sclr & ~st.prev[2];

      nx.thermal   = st.cfg[CFG_THERMAL] & lv_therm;
      nx.comp_gain = st.cfg[CFG_COMP] ? {lv_c2, lv_c1}
                                      : 2'h0;
      nx.flux      = lv_flux & DECEL_STOP;
      nx.dir_sub   = lv_dir;
      nx.servo     = lv_servo;
      nx.origin    = st.cfg[CFG_PHOTO] & lv_org;
      nx.home      = lv_home;
      nx.angle     = st.cfg[CFG_SPINDLE] ? {lv_a3, lv_a2, lv_a1}
                                         : 3'h0;
      nx.hold      = lv_home | (nx.angle != 3'h0);
      nx.pos_gain  = lv_pg;

      if (WR) begin
         case (ADDR)
            ADDR_LO_TIME: begin
               nx.lo_time = fn_clamp(WDATA);
            end
            ADDR_HI_TIME: begin
               nx.hi_time = fn_clamp(WDATA);
            end
            ADDR_POLARITY: begin
               nx.polarity = WDATA[POL_W-1:0];
            end
            ADDR_CONFIG: begin
               nx.cfg = WDATA[3:0];
            end
            default: begin
               if (ADDR >= ADDR_FUNC_BASE && fidx < 4'(NUM_TERM)) begin
                  nx.func[fidx] = WDATA[FUNC_W-1:0];
               end
            end
         endcase
      end

      nx.rdata = 16'h0000;
      if (RD) begin
         case (ADDR)
            ADDR_LO_TIME: begin
               nx.rdata = 16'(st.lo_time);
            end
            ADDR_HI_TIME: begin
               nx.rdata = 16'(st.hi_time);
            end
            ADDR_POLARITY: begin
               nx.rdata = 16'(st.polarity);
            end
            ADDR_CONFIG: begin
               nx.rdata = 16'(st.cfg);
            end
            ADDR_STATUS: begin
               nx.rdata = 16'({rate_ok, filt});
            end
            ADDR_COUNT: begin
               nx.rdata = count;
            end
            default: begin
               if (ADDR >= ADDR_FUNC_BASE && fidx < 4'(NUM_TERM)) begin
                  nx.rdata = 16'(st.func[fidx]);
               end
            end
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         st          <= '0;
         st.lo_time  <= TIME_W'(DEB_TIME_RST);
         st.hi_time  <= TIME_W'(DEB_TIME_RST);
         st.polarity <= POLARITY_RST;
         st.cfg      <= CONFIG_RST;
         st.func     <= {NUM_TERM{FUNC_RST}};
      end else begin
         st <= nx;
      end
   end

   // ==========================================================
   // Filter and pulse path
   input_debounce #(
      .N     (NUM_TERM),
      .LOW_N (LOW_GROUP)
   ) u_debounce (
      .clk     (CLK),
      .rst     (RST),
      .ms_tick (st.ms_tick),
      .raw     (st.raw),
      .lo_time (st.lo_time),
      .hi_time (st.hi_time),
      .filt    (filt)
   );

   // Pulse path skips the ms filter, which would eat the train
   pulse_train_counter #(
      .LO_MAX (LO_MAX),
      .HI_MAX (HI_MAX)
   ) u_pulse (
      .clk     (CLK),
      .rst     (RST),
      .level   (st.raw[NUM_TERM-1]),
      .enable  (pulse_en),
      .fast    (pulse_fast),
      .dir_sub (st.dir_sub),
      .clear   (st.srv_clr),
      .count   (count),
      .rate_ok (rate_ok)
   );

   assign RDATA             = st.rdata;
   assign TERM_STATE        = filt;
   assign LENGTH_CLEAR      = st.len_clr;
   assign THERMAL_SWITCH    = st.thermal;
   assign COMP_GAIN_SET     = st.comp_gain;
   assign FLUX_BRAKE        = st.flux;
   assign POS_COUNT_CLEAR   = st.pos_clr;
   assign SERVO_DIR_SUB     = st.dir_sub;
   assign SERVO_MODE        = st.servo;
   assign SPINDLE_ORIGIN    = st.origin;
   assign SPINDLE_HOME      = st.home;
   assign SPINDLE_ANGLE     = st.angle;
   assign SPINDLE_HOLD      = st.hold;
   assign POS_GAIN_SEL      = st.pos_gain;
   assign SERVO_COUNT_CLEAR = st.srv_clr;
   assign PULSE_COUNT       = count;
   assign PULSE_RATE_OK     = rate_ok;

   // ==========================================================
   // Checks
   AST_LEN_CLR: assert property (@(posedge CLK) disable iff (RST)
      $rose(lv_len) |=> LENGTH_CLEAR ##1 !LENGTH_CLEAR)
      else $error("Length clear not a single pulse on assertion");

   AST_THERMAL: assert property (@(posedge CLK) disable iff (RST)
      !st.cfg[CFG_THERMAL] |=> !THERMAL_SWITCH)
      else $error("Thermal input seen while not configured");

   AST_COMP: assert property (@(posedge CLK) disable iff (RST)
      st.cfg[CFG_COMP] |=> COMP_GAIN_SET == $past({lv_c2, lv_c1}))
      else $error("Compensation gain set mismatch");

   AST_FLUX: assert property (@(posedge CLK) disable iff (RST)
      !DECEL_STOP |=> !FLUX_BRAKE)
      else $error("Flux brake outside decelerating stop");

   AST_HOLD: assert property (@(posedge CLK) disable iff (RST)
      SPINDLE_ANGLE == 3'h0 && !SPINDLE_HOME |-> !SPINDLE_HOLD)
      else $error("Torque held in normal operation");

   AST_POL_READ: assert property (@(posedge CLK) disable iff (RST)
      RD && ADDR == ADDR_POLARITY |=> RDATA == 16'($past(st.polarity)))
      else $error("Polarity readback wrong");

   AST_TIME_RANGE: assert property (@(posedge CLK) disable iff (RST)
      WR && ADDR == ADDR_LO_TIME |=> st.lo_time >= TIME_W'(DEB_TIME_MIN)
         && st.lo_time <= TIME_W'(DEB_TIME_MAX))
      else $error("Filter time outside 1 to 50 ms");

   AST_RAW_POL: assert property (@(posedge CLK) disable iff (RST)
      ##1 st.raw == ($past(TERM_CLOSED) ^ $past(st.polarity[NUM_TERM-1:0])))
      else $error("Polarity not applied to raw level");

endmodule : input_terminal_conditioning
`default_nettype wire

// [test/contact_bank.sv]
`timescale 1ns/100ps
`default_nettype none
module contact_bank (
   input  wire logic       CLK,
   input  wire logic [8:0] cmd,
   input  wire logic       run,
   input  var  int         half,
   output logic      [8:0] closed,
   output var  int         rises
);
   // ==========================================================
   // Pulse source on the pulse-capable terminal
   // Idles open between bursts so no stray edge is counted
   logic level = 1'b0;
   int   cnt = 0;
   int   rise_n = 0;
   always @(posedge CLK) begin
      if (!run) begin
         level <= 1'b0;
         cnt <= 0;
      end else if (cnt >= half - 1) begin
         cnt <= 0;
         level <= !level;
         if (!level) begin
            rise_n <= rise_n + 1;
         end
      end else begin
         cnt <= cnt + 1;
      end
   end
   assign rises  = rise_n;
   assign closed = {cmd[8] | level, cmd[7:0]};
endmodule : contact_bank
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import term_cond_pkg::*;
   logic        clk, rst, decel, wr, rd, run;
   logic [3:0]  addr;
   logic [15:0] wdata, rdata, cnt;
   logic [8:0]  cmd, closed, state;
   logic        len_clr, therm, flux, pos_clr, dir_sub, servo, origin;
   logic        home, hold, pgain, srv_clr, rate_ok;
   logic [1:0]  comp;
   logic [2:0]  angle;
   int          half, rises, error_cnt, check_count, base;
   int          len_n = 0;
   int          pos_n = 0;
   int          srv_n = 0;
   logic [15:0] d;

   // ==========================================================
   // Clock, partner and design
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   contact_bank u_contact_bank (.CLK(clk), .cmd(cmd), .run(run),
      .half(half), .closed(closed), .rises(rises));
   // Short ms tick and period limits keep the run brief
   input_terminal_conditioning #(.MS_CYCLES(10), .LO_MAX(2000),
      .HI_MAX(200)) u_input_terminal_conditioning (
      .CLK(clk), .RST(rst), .TERM_CLOSED(closed), .DECEL_STOP(decel),
      .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .TERM_STATE(state), .LENGTH_CLEAR(len_clr),
      .THERMAL_SWITCH(therm), .COMP_GAIN_SET(comp), .FLUX_BRAKE(flux),
      .POS_COUNT_CLEAR(pos_clr), .SERVO_DIR_SUB(dir_sub),
      .SERVO_MODE(servo), .SPINDLE_ORIGIN(origin), .SPINDLE_HOME(home),
      .SPINDLE_ANGLE(angle), .SPINDLE_HOLD(hold), .POS_GAIN_SEL(pgain),
      .SERVO_COUNT_CLEAR(srv_clr), .PULSE_COUNT(cnt),
      .PULSE_RATE_OK(rate_ok));
   // One-cycle strobes are tallied so a late look still sees them
   always @(posedge clk) begin
      if (len_clr === 1'b1) len_n <= len_n + 1;
      if (pos_clr === 1'b1) pos_n <= pos_n + 1;
      if (srv_clr === 1'b1) srv_n <= srv_n + 1;
   end

   // ==========================================================
   // Bus, checking and closing tasks
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask : rd_reg
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
      rd_reg(a, d);
      chk(d, exp);
   endtask : rchk
   // Worst case filter settle for 5 ms at 10 cycles per ms
   task automatic settle(input logic [8:0] c);
      @(posedge clk);
      cmd <= c;
      repeat (90) @(posedge clk);
   endtask : settle
   task automatic set_funcs(input logic [6:0] f [9]);
      for (int i = 0; i < 9; i++) wr_reg(ADDR_FUNC_BASE + 4'(i), 16'(f[i]));
   endtask : set_funcs
   task automatic burst(input int h, input int n);
      int t;
      t = 0;
      base = rises;
      half <= h;
      run <= 1'b1;
      while (rises < base + n && t < 20000) begin
         @(posedge clk);
         t++;
      end
      run <= 1'b0;
      if (t >= 20000) chk(16'h0bad, 16'h0000);
      repeat (5) @(posedge clk);
   endtask : burst
   task automatic finish_test;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : finish_test
   initial begin
      repeat (40000) @(posedge clk);
      error_cnt++;
      finish_test();
   end

   // ==========================================================
   // Scenarios
   initial begin
      {rst, decel, wr, rd, run, addr, wdata, cmd} = '0;
      {error_cnt, check_count, base} = '0;
      rst = 1'b1;
      half = 75;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rchk(ADDR_LO_TIME, 16'h0005);
      rchk(ADDR_HI_TIME, 16'h0005);
      rchk(ADDR_POLARITY, 16'h0000);
      rchk(4'hf, 16'h0000);
      wr_reg(ADDR_LO_TIME, 16'h0040);
      rchk(ADDR_LO_TIME, 16'h0032);
      wr_reg(ADDR_LO_TIME, 16'h0005);
      wr_reg(ADDR_HI_TIME, 16'h0000);
      rchk(ADDR_HI_TIME, 16'h0001);
      wr_reg(ADDR_HI_TIME, 16'h0005);
      wr_reg(ADDR_POLARITY, 16'h0fff);
      rchk(ADDR_POLARITY, 16'h0fff);
      wr_reg(ADDR_POLARITY, 16'h0000);
      wr_reg(ADDR_CONFIG, 16'h000f);
      set_funcs('{7'd61, 7'd62, 7'd63, 7'd64, 7'd65, 7'd66, 7'd69, 7'd75,
                  7'd98});
      settle(9'h07e);
      chk(16'(state), 16'h007e);
      chk(16'({therm, comp, servo, flux}), 16'h001e);
      chk(16'(pos_n), 16'h0001);
      decel <= 1'b1;
      repeat (3) @(posedge clk);
      chk(16'(flux), 16'h0001);
      for (int k = 0; k < 4; k++) begin
         settle({7'h00, 2'(k)} << 2);
         chk(16'(comp), 16'(k));
      end
      wr_reg(ADDR_CONFIG, 16'h0000);
      repeat (3) @(posedge clk);
      chk(16'({therm, comp}), 16'h0000);
      // Glitch of about 4 ms, two ticks short of the 5 ms filter
      @(posedge clk);
      cmd <= 9'h080;
      repeat (40) @(posedge clk);
      settle(9'h000);
      chk(16'(pgain), 16'h0000);
      repeat (30) @(posedge clk);
      settle(9'h080);
      chk(16'(pgain), 16'h0001);
      settle(9'h001);
      chk(16'(len_n), 16'h0001);
      settle(9'h000);
      wr_reg(ADDR_POLARITY, 16'h0001);
      settle(9'h000);
      chk(16'(state), 16'h0001);
      chk(16'(len_n), 16'h0002);
      wr_reg(ADDR_POLARITY, 16'h0000);
      wr_reg(ADDR_CONFIG, 16'h000f);
      set_funcs('{7'd72, 7'd73, 7'd74, 7'd71, 7'd70, 7'd68, 7'd77, 7'd75,
                  7'd98});
      for (int a = 0; a < 8; a++) begin
         settle(9'(a));
         chk(16'({hold, angle}), 16'({a != 0, 3'(a)}));
      end
      settle(9'h018);
      chk(16'({home, hold, origin}), 16'h0007);
      settle(9'h040);
      chk(cnt, 16'h0000);
      settle(9'h000);
      chk(16'({home, hold}), 16'h0000);
      burst(75, 20);
      chk(cnt, 16'd20);
      chk(16'(rate_ok), 16'h0001);
      settle(9'h020);
      chk(16'(dir_sub), 16'h0001);
      burst(75, 10);
      chk(cnt, 16'd10);
      wr_reg(ADDR_FUNC_BASE + 4'h8, 16'd97);
      burst(75, 3);
      chk(16'(rate_ok), 16'h0000);
      burst(700, 3);
      chk(16'(rate_ok), 16'h0001);
      rchk(ADDR_STATUS, 16'h0220);
      rchk(ADDR_COUNT, 16'h0004);
      settle(9'h040);
      chk(cnt, 16'h0000);
      chk(16'(srv_n), 16'h0002);
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
